// >>> core/one_shot_defines.svh
`ifndef ONE_SHOT_DEFINES_SVH
`define ONE_SHOT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADR_CTRL    8'h00
`define ADR_COUNT   8'h04
`define ADR_PERIOD  8'h08
`define ADR_DUTY    8'h0c
`define ADR_STATUS  8'h10
`define ADR_MASK    8'h14
`define ADR_STATE   8'h18

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define CTRL_W       10
`define CTRL_RST     10'h000
`define CHRST_BIT    31
`define IRQ_N        2
`define CNT_STEP     1
`define BYTE_W       8
`define SEL_W        4
`define DATA_W       32
`define STATE_PH_LSB 1
`define STATE_PH_W   2
`define STATE_LVL_BIT 0
`define CLK_SEL_W    3

`endif

// >>> core/one_shot_pkg.sv
package one_shot_pkg;

  // ----------------------------------------------------------------------
  // Channel phases
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INITIAL,
    ST_PULSE
  } phase_t;

  // ----------------------------------------------------------------------
  // Control register, bit 0 first from the right
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clk_sel;
    logic       active_high;
    logic [1:0] up_down_count_select;
    logic       single_output_pwm_mode;
    logic       one_shot_trigger_select;
    logic       one_shot_select;
    logic       chan_en;
  } ctrl_t;

  // ----------------------------------------------------------------------
  // Compare trigger pair
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic compare1_trigger;
    logic compare0_trigger;
  } trig_t;

endpackage

// >>> core/compare_unit.sv
`timescale 1ns/10ps
module compare_unit #(
  parameter int CNT_W = 16
) (
  // Counter side
  input  wire logic [CNT_W-1:0] count_in,
  input  wire logic [CNT_W-1:0] compare_in,
  input  wire logic             tick_in,
  input  wire logic             running_in,
  // Result
  output logic                  hit_out
);
  `include "one_shot_defines.svh"

  // Compares in every running phase, the initial one included
  assign hit_out = running_in && tick_in &&
                   (count_in == compare_in - CNT_W'(`CNT_STEP));

endmodule

// >>> core/irq_block.sv
`timescale 1ns/10ps
module irq_block #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // Events
  input  wire logic [N-1:0] set_in,
  // Software access
  input  wire logic         clr_wr_in,
  input  wire logic         mask_wr_in,
  input  wire logic [N-1:0] data_in,
  // State
  output logic      [N-1:0] status_out,
  output logic      [N-1:0] mask_out,
  output logic              irq_out
);
  logic [N-1:0] status_nxt;
  logic [N-1:0] mask_nxt;
  logic         irq_nxt;

  // Set wins over a same-cycle write-one clear
  always_comb begin
    status_nxt = status_out;
    mask_nxt   = mask_out;
    if (clr_wr_in) begin
      status_nxt = status_nxt & ~data_in;
    end
    status_nxt = status_nxt | set_in;
    if (mask_wr_in) begin
      mask_nxt = data_in;
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_out <= '0;
      mask_out   <= '0;
      irq_out    <= 1'b0;
    end else begin
      status_out <= status_nxt;
      mask_out   <= mask_nxt;
      irq_out    <= irq_nxt;
    end
  end

endmodule

// >>> core/one_shot_channel.sv
// Behaviour
// - Count write, trigger select clear: start one-shot, inactive first.
// - Write start: initial phase is period compare minus written count.
// - At period compare minus one: active edge, count clears, counts on.
// - In pulse, at duty compare minus one: inactive edge ends pulse.
// - Both compare units also fire triggers in the initial phase.
// - Every compare trigger sets its pending flag; enabled ones raise interrupt.
// - Trigger select and one-shot select set: chain or capture trigger clears count, starts.
// - Trigger start: initial phase ends at count of period minus one.
// - While enabled with trigger select clear, a new counter write starts another full one-shot.
`timescale 1ns/10ps
module one_shot_channel
  import one_shot_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int CLK_N = 8
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  // Wishbone slave
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic [7:0]         wb_adr_in,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic [31:0]        wb_dat_in,
  output logic      [31:0]        wb_dat_out,
  output logic                    wb_ack_out,
  // Cluster clock enables and start triggers
  input  wire logic [CLK_N-1:0]   clk_en_in,
  input  wire logic               chain_trigger_in,
  input  wire logic               external_capture_trigger_in,
  // Channel outputs
  output logic                    pwm_out,
  output logic                    sequencer_output_path_out,
  output logic                    chain_trigger_out,
  output logic                    compare0_trigger_out,
  output logic                    compare1_trigger_out,
  output logic                    irq_out
);
  `include "one_shot_defines.svh"

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > `DATA_W) begin : g_bad_cnt_w
    $error("CNT_W must lie between 2 and 32");
  end
  if (CLK_N < 1 || CLK_N > (1 << `CLK_SEL_W)) begin : g_bad_n
    $error("CLK_N must lie between 1 and 8");
  end
  if ($bits(ctrl_t) != `CTRL_W) begin : g_bad_ctrl
    $error("Control layout and its width constant disagree");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ctrl_t             ctrl_r;
  ctrl_t             ctrl_nxt;
  logic [CNT_W-1:0]  period_r;
  logic [CNT_W-1:0]  period_nxt;
  logic [CNT_W-1:0]  duty_r;
  logic [CNT_W-1:0]  duty_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  phase_t            phase_r;
  phase_t            phase_nxt;
  logic              level_r;
  logic              level_nxt;
  logic              ack_nxt;
  logic [31:0]       rdata_nxt;
  logic              pwm_nxt;
  trig_t             trig_nxt;
  logic [31:0]       wmask;
  logic              req;
  logic              wr;
  logic              wr_ctrl;
  logic              wr_cnt;
  logic              chan_rst;
  logic              tick;
  logic              running;
  logic [31:0]       cur_word;
  logic [31:0]       new_word;
  logic [CNT_W-1:0]  cmp_val [`IRQ_N];
  logic [`IRQ_N-1:0] hit;
  logic [`IRQ_N-1:0] status;
  logic [`IRQ_N-1:0] mask;
  logic              wr_period;
  logic              wr_duty;
  logic              wr_status;
  logic              wr_mask;
  logic              sw_start;
  logic              hw_start;
  logic [31:0]       state_word;
  logic [`IRQ_N-1:0] irq_wdata;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Writes land on the edge where the master sees ack, never earlier
  assign req      = wb_cyc_in && wb_stb_in;
  assign wr       = req && wb_we_in && wb_ack_out;
  assign wr_ctrl  = wr && (wb_adr_in == `ADR_CTRL);
  assign wr_cnt   = wr && (wb_adr_in == `ADR_COUNT);
  assign chan_rst = wr_ctrl && wb_sel_in[`SEL_W-1] && wb_dat_in[`CHRST_BIT];
  assign wr_period = wr && (wb_adr_in == `ADR_PERIOD);
  assign wr_duty   = wr && (wb_adr_in == `ADR_DUTY);
  assign wr_status = wr && (wb_adr_in == `ADR_STATUS);
  assign wr_mask   = wr && (wb_adr_in == `ADR_MASK);

  for (genvar b = 0; b < `SEL_W; b++) begin : g_lane
    assign wmask[b*`BYTE_W +: `BYTE_W] = {`BYTE_W{wb_sel_in[b]}};
  end

  // Phase and level readback at fixed bit positions
  always_comb begin
    state_word                               = '0;
    state_word[`STATE_LVL_BIT]               = level_r;
    state_word[`STATE_PH_LSB +: `STATE_PH_W] = phase_r;
  end

  always_comb begin
    case (wb_adr_in)
      `ADR_CTRL:   cur_word = `DATA_W'(ctrl_r);
      `ADR_COUNT:  cur_word = `DATA_W'(cnt_r);
      `ADR_PERIOD: cur_word = `DATA_W'(period_r);
      `ADR_DUTY:   cur_word = `DATA_W'(duty_r);
      `ADR_STATUS: cur_word = `DATA_W'(status);
      `ADR_MASK:   cur_word = `DATA_W'(mask);
      `ADR_STATE:  cur_word = state_word;
      default:     cur_word = '0;
    endcase
  end

  assign new_word = (cur_word & ~wmask) | (wb_dat_in & wmask);

  // A write-one clear must not mistake merged read-back bits for ones
  assign irq_wdata = wr_status ?
                     (wb_dat_in[`IRQ_N-1:0] & wmask[`IRQ_N-1:0]) :
                     new_word[`IRQ_N-1:0];

  // ----------------------------------------------------------------------
  // Bus answer and configuration registers
  // ----------------------------------------------------------------------
  always_comb begin
    ack_nxt    = req && !wb_ack_out;
    rdata_nxt  = ack_nxt ? cur_word : '0;
    ctrl_nxt   = ctrl_r;
    period_nxt = period_r;
    duty_nxt   = duty_r;
    if (wr_ctrl) begin
      ctrl_nxt = ctrl_t'(new_word[`CTRL_W-1:0]);
    end
    if (wr_period) begin
      period_nxt = new_word[CNT_W-1:0];
    end
    if (wr_duty) begin
      duty_nxt = new_word[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
      ctrl_r     <= ctrl_t'(`CTRL_RST);
      period_r   <= '0;
      duty_r     <= '0;
    end else begin
      wb_ack_out <= ack_nxt;
      wb_dat_out <= rdata_nxt;
      ctrl_r     <= ctrl_nxt;
      period_r   <= period_nxt;
      duty_r     <= duty_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Clock enable and compare units
  // ----------------------------------------------------------------------
  // An out-of-range selection gives no enable rather than an X index
  assign tick    = (int'(ctrl_r.clk_sel) < CLK_N) &&
                   clk_en_in[ctrl_r.clk_sel];
  assign running = ctrl_r.chan_en && (phase_r != ST_IDLE);
  assign cmp_val[0] = period_r;
  assign cmp_val[1] = duty_r;

  for (genvar g = 0; g < `IRQ_N; g++) begin : g_cmp
    compare_unit #(
      .CNT_W      (CNT_W)
    ) u_cmp (
      .count_in   (cnt_r),
      .compare_in (cmp_val[g]),
      .tick_in    (tick),
      .running_in (running),
      .hit_out    (hit[g])
    );
  end

  // ----------------------------------------------------------------------
  // Start decode
  // ----------------------------------------------------------------------
  // Trigger inputs count only with trigger select set, so a stray chain
  // pulse cannot restart a software-timed shot
  assign sw_start = wr_cnt && !ctrl_r.one_shot_trigger_select;
  assign hw_start = ctrl_r.one_shot_trigger_select &&
                    ctrl_r.one_shot_select &&
                    (chain_trigger_in || external_capture_trigger_in);

  // ----------------------------------------------------------------------
  // Counter and phase sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_nxt   = cnt_r;
    phase_nxt = phase_r;
    level_nxt = level_r;
    if (chan_rst || !ctrl_r.chan_en) begin
      cnt_nxt   = chan_rst ? '0 : cnt_r;
      phase_nxt = ST_IDLE;
      level_nxt = 1'b0;
    end else if (sw_start) begin
      // Every write restarts from a clean initial phase
      cnt_nxt   = new_word[CNT_W-1:0];
      phase_nxt = ST_INITIAL;
      level_nxt = 1'b0;
    end else if (hw_start) begin
      cnt_nxt   = '0;
      phase_nxt = ST_INITIAL;
      level_nxt = 1'b0;
    end else if (!ctrl_r.one_shot_select && phase_r == ST_IDLE) begin
      cnt_nxt   = '0;
      phase_nxt = ST_PULSE;
      level_nxt = 1'b1;
    end else if (tick && phase_r != ST_IDLE) begin
      if (hit[0]) begin
        cnt_nxt = '0;
        if (phase_r == ST_INITIAL || !ctrl_r.one_shot_select) begin
          phase_nxt = ST_PULSE;
          level_nxt = 1'b1;
        end else begin
          phase_nxt = ST_IDLE;
          level_nxt = 1'b0;
        end
      end else begin
        cnt_nxt = cnt_r + CNT_W'(`CNT_STEP);
        if (hit[1] && phase_r == ST_PULSE) begin
          level_nxt = 1'b0;
        end
      end
    end
    pwm_nxt = ctrl_r.active_high ? level_nxt : !level_nxt;
    trig_nxt.compare0_trigger = hit[0];
    trig_nxt.compare1_trigger = hit[1];
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r                     <= '0;
      phase_r                   <= ST_IDLE;
      level_r                   <= 1'b0;
      pwm_out                   <= 1'b0;
      sequencer_output_path_out <= 1'b0;
      chain_trigger_out         <= 1'b0;
      compare0_trigger_out      <= 1'b0;
      compare1_trigger_out      <= 1'b0;
    end else begin
      cnt_r                     <= cnt_nxt;
      phase_r                   <= phase_nxt;
      level_r                   <= level_nxt;
      pwm_out                   <= pwm_nxt;
      // Sequencer copy stays valid in every count mode
      sequencer_output_path_out <= pwm_nxt;
      chain_trigger_out         <= trig_nxt.compare0_trigger;
      compare0_trigger_out      <= trig_nxt.compare0_trigger;
      compare1_trigger_out      <= trig_nxt.compare1_trigger;
    end
  end

  // ----------------------------------------------------------------------
  // Pending flags and interrupt
  // ----------------------------------------------------------------------
  irq_block #(
    .N          (`IRQ_N)
  ) u_irq (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .set_in     ({trig_nxt.compare1_trigger,
                  trig_nxt.compare0_trigger}),
    .clr_wr_in  (wr_status),
    .mask_wr_in (wr_mask),
    .data_in    (irq_wdata),
    .status_out (status),
    .mask_out   (mask),
    .irq_out    (irq_out)
  );

endmodule

// >>> verif/one_shot_assertions.sv
`timescale 1ns/10ps
module one_shot_assertions #(
  parameter int CLK_N = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  // Bus
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [31:0]      wb_dat_out,
  input  wire logic             wb_ack_out,
  // Channel
  input  wire logic [CLK_N-1:0] clk_en_in,
  input  wire logic             pwm_out,
  input  wire logic             chain_trigger_out,
  input  wire logic             compare0_trigger_out,
  input  wire logic             compare1_trigger_out,
  input  wire logic             irq_out
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  logic wr_done;
  logic ev;
  assign wr_done = wb_ack_out & wb_we_in;
  assign ev = wr_done | compare0_trigger_out | compare1_trigger_out;

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_ACK_LATENCY: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack not one cycle after request");
  AST_ACK_NEEDS_REQ: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in)
    else $error("ack without request");
  AST_DATA_IDLE: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  AST_CHAIN_FOLLOWS: assert property (
    chain_trigger_out == compare0_trigger_out)
    else $error("chain output differs from compare0 trigger");
  AST_TRIG_ON_TICK: assert property (
    compare0_trigger_out || compare1_trigger_out |-> $past(|clk_en_in))
    else $error("compare trigger without clock enable");
  // Level changes only at a compare hit, a write, or leaving reset
  AST_PWM_CAUSE: assert property (
    $changed(pwm_out) |-> compare0_trigger_out || compare1_trigger_out
      || $past(wr_done) || $past(wr_done, 2)
      || $past(sys_rst_in) || $past(sys_rst_in, 2))
    else $error("output edge without cause");
  AST_IRQ_RISE: assert property (
    $rose(irq_out) |-> ev || $past(ev) || $past(ev, 2))
    else $error("interrupt rose without event");
  AST_IRQ_FALL: assert property (
    $fell(irq_out) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("interrupt fell without write");
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
`include "one_shot_defines.svh"
module tb;
  import one_shot_pkg::*;
  logic        clk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [7:0]  wb_adr_in, clk_en_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic        wb_ack_out, chain_trigger_in, external_capture_trigger_in;
  logic        pwm_out, sequencer_output_path_out, chain_trigger_out;
  logic        compare0_trigger_out, compare1_trigger_out, irq_out;
  logic        rnd_en;
  logic [9:0]  ctl;
  logic [1:0]  m;
  int          fails, num_checks, seed, p, d, c;

  one_shot_channel #(.CNT_W(16), .CLK_N(8)) i_one_shot_channel (.*);

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Random enables stress the tick logic; expectations count real ticks
  always @(posedge clk_in) begin
    clk_en_in <= rnd_en ? 8'($random(seed)) : 8'hff;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= w;
    wb_adr_in <= a;
    wb_dat_in <= v;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (wb_ack_out !== 1'b1) begin
      fails++;
      wrap_up;
    end
  endtask

  task automatic trig(input logic ext);
    @(posedge clk_in);
    chain_trigger_in <= !ext;
    external_capture_trigger_in <= ext;
    @(posedge clk_in);
    chain_trigger_in <= 1'b0;
    external_capture_trigger_in <= 1'b0;
  endtask

  // Follows one whole one-shot, counting ticks of the selected enable
  task automatic shot(input int first, input int ini1);
    int   nt, n, c0, c1, tr, tf;
    logic tk;
    nt = 0;
    n = 0;
    c0 = 0;
    c1 = 0;
    tr = -1;
    tf = -1;
    while (nt < first + p && n < 2000) begin
      @(posedge clk_in);
      tk = clk_en_in[ctl[9:7]];
      #1;
      n++;
      nt += tk;
      c0 += (compare0_trigger_out === 1'b1);
      c1 += (compare1_trigger_out === 1'b1);
      if (pwm_out === ctl[6] && tr < 0)
        tr = nt;
      if (pwm_out !== ctl[6] && tr >= 0 && tf < 0)
        tf = nt;
    end
    if (n >= 2000) begin
      fails++;
      wrap_up;
    end
    chk(tr, first);
    chk(tf - tr, d);
    chk(c0, 2);
    chk(c1, 1 + ini1);
    chk(pwm_out, !ctl[6]);
    chk(sequencer_output_path_out, !ctl[6]);
  endtask

  task automatic irq_chk;
    wb(1'b0, `ADR_STATUS, 32'h0);
    chk(rd[1:0], 2'h3);
    chk(irq_out, |m);
    wb(1'b1, `ADR_STATUS, 32'h3);
    wb(1'b0, `ADR_STATUS, 32'h0);
    chk(rd[1:0], 2'h0);
    chk(irq_out, 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 98275;
    fails = 0;
    num_checks = 0;
    rnd_en = 1'b0;
    sys_rst_in = 1'b1;
    {wb_cyc_in, wb_stb_in, wb_we_in} = 3'h0;
    wb_adr_in = 8'h00;
    wb_sel_in = 4'hf;
    wb_dat_in = 32'h0;
    clk_en_in = 8'hff;
    chain_trigger_in = 1'b0;
    external_capture_trigger_in = 1'b0;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wb(1'b0, `ADR_CTRL, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h40, 32'hffffffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rnd_en <= i[0];
      p = 2 + {$random(seed)} % 12;
      d = 1 + {$random(seed)} % (p - 1);
      c = {$random(seed)} % p;
      // Counts that start at or past a compare point are the awkward ones
      if (i == 1)
        c = p - 1;
      if (i == 2)
        c = d - 1;
      m = 2'($random(seed));
      ctl = {3'($random(seed)), 1'($random(seed)), 3'h1,
             i >= 6, 1'b1, 1'b1};
      wb(1'b1, `ADR_PERIOD, p);
      wb(1'b1, `ADR_DUTY, d);
      wb(1'b1, `ADR_MASK, {30'h0, m});
      wb(1'b1, `ADR_CTRL, {22'h0, ctl});
      if (i < 6) begin
        if (i[0])
          wb(1'b1, `ADR_COUNT, 32'h0);
        wb(1'b1, `ADR_COUNT, c);
        shot(p - c, c < d);
      end else begin
        trig(i[0]);
        shot(p, 1);
      end
      irq_chk;
      $display("test %0d done", i);
    end
    // Channel reset returns a started shot to idle with a cleared count
    wb(1'b1, `ADR_CTRL, 32'h3);
    wb(1'b1, `ADR_COUNT, 32'h8000);
    wb(1'b0, `ADR_STATE, 32'h0);
    chk(rd, 32'h2);
    chk(pwm_out, 1'b1);
    wb(1'b1, `ADR_CTRL, 32'h80000003);
    wb(1'b0, `ADR_COUNT, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, `ADR_STATE, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    wrap_up;
  end
endmodule

bind one_shot_channel one_shot_assertions #(.CLK_N(CLK_N))
  i_one_shot_assertions (.*);
